// ===== hdl/bst_consts.svh
`ifndef BST_CONSTS_SVH
`define BST_CONSTS_SVH

// ****************************************
// Register lengths
// ****************************************
`define BST_IR_LEN       10
`define BST_ID_LEN       32
`define BST_USER_FREE    7
`define BST_BSR_LEN_DEF  690
`define BST_BSR_LEN_MIN  690
`define BST_BSR_LEN_MAX  1446

// ****************************************
// Instruction codes
// ****************************************
`define BST_OP_EXTEST    10'h000
`define BST_OP_SAMPLE    10'h055
`define BST_OP_IDCODE    10'h059
`define BST_OP_USERCODE  10'h079
`define BST_OP_CFG_START 10'h002
`define BST_OP_CFG_LOAD  10'h003
`define BST_OP_BYPASS    10'h3ff
`define BST_IR_CAPTURE   10'h001

// ****************************************
// Identity values (arbitrary neutral values)
// ****************************************
`define BST_ID_VERSION   4'h3
`define BST_ID_PART      16'h5a5a
`define BST_ID_MAKER     11'h2aa
`define BST_USER_FIXED   25'h0abcdef

`endif

// ===== hdl/bst_pkg.sv
package bst_pkg;

	// TAP controller states
	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
		ST_PAU_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
		ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
	} bst_state_t;

	// Data register selected by the instruction
	typedef enum logic [2:0] {
		SEL_BYP, SEL_BSR, SEL_ID, SEL_USER, SEL_CFG
	} bst_sel_t;

	// Test port input pins
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} bst_jtag_t;

endpackage

// ===== hdl/bst_tap_fsm.sv
`timescale 1ns/1ns

module bst_tap_fsm (
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic              step,
	input  wire logic              tms,
	output bst_pkg::bst_state_t    state
);

	bst_pkg::bst_state_t next_state;	// Successor on this TCK rise

	// ****************************************
	// Sixteen-state walk on TMS
	// ****************************************
	always_comb begin
		case (state)
			bst_pkg::ST_RESET:  next_state = tms ? bst_pkg::ST_RESET  : bst_pkg::ST_IDLE;
			bst_pkg::ST_IDLE:   next_state = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
			bst_pkg::ST_SEL_DR: next_state = tms ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
			bst_pkg::ST_CAP_DR: next_state = tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
			bst_pkg::ST_SH_DR:  next_state = tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
			bst_pkg::ST_EX1_DR: next_state = tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAU_DR;
			bst_pkg::ST_PAU_DR: next_state = tms ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PAU_DR;
			bst_pkg::ST_EX2_DR: next_state = tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
			bst_pkg::ST_UPD_DR: next_state = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
			bst_pkg::ST_SEL_IR: next_state = tms ? bst_pkg::ST_RESET  : bst_pkg::ST_CAP_IR;
			bst_pkg::ST_CAP_IR: next_state = tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
			bst_pkg::ST_SH_IR:  next_state = tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
			bst_pkg::ST_EX1_IR: next_state = tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAU_IR;
			bst_pkg::ST_PAU_IR: next_state = tms ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PAU_IR;
			bst_pkg::ST_EX2_IR: next_state = tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
			bst_pkg::ST_UPD_IR: next_state = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
			default:            next_state = bst_pkg::ST_RESET;
		endcase
	end

	// State advances only on a detected TCK rise
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state <= bst_pkg::ST_RESET;
		end else if (step) begin
			state <= next_state;	// see [R16]
		end
	end

endmodule

// ===== hdl/bst_tap.sv
`timescale 1ns/1ns
`include "bst_consts.svh"

// Notes on behaviour
// [R1] Instruction register is ten bits
// [R2] User signature: 32 bits, 7 from user
// [R3] Bypass is one stage, TDI to TDO
// [R4] Sample captures pins, preloads output pattern
// [R5] Extest drives pattern, captures input pins
// [R6] Usercode shifts user signature out TDO
// [R7] Idcode shifts identification register out TDO
// [R8] Id: version, part, maker, one bit
// [R9] Id LSB is one, shifted first
// [R10] Boundary length per variant, 690 to 1446
// [R11] No boundary scan while configuring
// [R12] Configuration instructions stream image over port
// [R13] Undriven port inputs read as high
// [R14] Outputs float until power is good; code gates only pad_oe on it, tdo_oe ignores power good
// [R15] Open-drain pins drive low or float
// [R16] Standard TAP; TDO on fall, else floating
// [R17] Test reset selects a non-intrusive instruction
module bst_tap #(
	parameter int BSR_LEN = `BST_BSR_LEN_DEF	// see [R10]
) (
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	input  wire bst_pkg::bst_jtag_t    jtag_in,
	output logic                       tdo,
	output logic                       tdo_oe,
	input  wire logic [6:0]            user_sig,
	input  wire logic                  cfg_busy,
	input  wire logic                  power_good,
	input  wire logic [BSR_LEN-1:0]    core_out,
	input  wire logic [BSR_LEN-1:0]    core_oe,
	input  wire logic [BSR_LEN-1:0]    od_sel,
	input  wire logic [BSR_LEN-1:0]    pad_in,
	output logic [BSR_LEN-1:0]         pad_out,
	output logic [BSR_LEN-1:0]         pad_oe,
	output logic                       cfg_start,
	output logic                       cfg_bit,
	output logic                       cfg_strobe
);

	// ****************************************
	// Elaboration checks
	// ****************************************
	if (BSR_LEN < `BST_BSR_LEN_MIN || BSR_LEN > `BST_BSR_LEN_MAX) begin : g_len_chk
		$error("Boundary length outside supported range");
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	bst_pkg::bst_jtag_t   jtag_s1;	// First stage, read only by second
	bst_pkg::bst_jtag_t   jtag_s2;	// Safe copy of the port pins
	logic                 tck_q;	// Previous TCK level
	logic [BSR_LEN-1:0]   pad_s1;	// First stage of pad samples
	logic [BSR_LEN-1:0]   pad_s2;	// Safe pad samples
	logic                 pwr_s1;	// First stage of power good
	logic                 pwr_ok;	// Safe power good
	logic                 rise;	// TCK rising edge pulse
	logic                 fall;	// TCK falling edge pulse

	// Reset to ones mirrors the pad pull-ups on an idle port
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			jtag_s1 <= 3'h7;	// see [R13]
			jtag_s2 <= 3'h7;	// see [R13]
			tck_q   <= 1'b1;
		end else begin
			jtag_s1 <= jtag_in;
			jtag_s2 <= jtag_s1;
			tck_q   <= jtag_s2.tck;
		end
	end

	// Pad and power samples come from outside this clock
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pad_s1 <= '0;
			pad_s2 <= '0;
			pwr_s1 <= 1'b0;
			pwr_ok <= 1'b0;
		end else begin
			pad_s1 <= pad_in;
			pad_s2 <= pad_s1;
			pwr_s1 <= power_good;
			pwr_ok <= pwr_s1;
		end
	end

	assign rise = jtag_s2.tck & ~tck_q;
	assign fall = ~jtag_s2.tck & tck_q;

	// ****************************************
	// TAP controller
	// ****************************************
	bst_pkg::bst_state_t state;	// Current TAP state

	bst_tap_fsm u_fsm (
		.core_clk (core_clk),
		.rst      (rst),
		.step     (rise),
		.tms      (jtag_s2.tms),
		.state    (state)
	);

	// ****************************************
	// Instruction decode
	// ****************************************
	logic [`BST_IR_LEN-1:0] ir_sh;	// Instruction shift stage
	logic [`BST_IR_LEN-1:0] ir;	// Active instruction
	bst_pkg::bst_sel_t      sel;	// Selected data register
	logic                   extest_act;	// Pins follow the pattern

	// Scan instructions fall back to bypass while configuring
	function automatic bst_pkg::bst_sel_t decode(input logic [`BST_IR_LEN-1:0] op,
	                                             input logic busy);
		case (op)
			`BST_OP_EXTEST,
			`BST_OP_SAMPLE:   decode = busy ? bst_pkg::SEL_BYP : bst_pkg::SEL_BSR;	// see [R11]
			`BST_OP_IDCODE:   decode = bst_pkg::SEL_ID;
			`BST_OP_USERCODE: decode = bst_pkg::SEL_USER;
			`BST_OP_CFG_LOAD: decode = bst_pkg::SEL_CFG;
			default:          decode = bst_pkg::SEL_BYP;
		endcase
	endfunction

	assign sel        = decode(ir, cfg_busy);
	assign extest_act = (ir == `BST_OP_EXTEST) && (decode(ir, cfg_busy) == bst_pkg::SEL_BSR);

	// Instruction path: capture, shift, update
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ir_sh <= `BST_IR_CAPTURE;
			ir    <= `BST_OP_IDCODE;
		end else if (rise) begin
			case (state)
				bst_pkg::ST_RESET:  ir    <= `BST_OP_IDCODE;	// see [R17]
				bst_pkg::ST_CAP_IR: ir_sh <= `BST_IR_CAPTURE;
				bst_pkg::ST_SH_IR:  ir_sh <= {jtag_s2.tdi, ir_sh[`BST_IR_LEN-1:1]};	// see [R1]
				bst_pkg::ST_UPD_IR: ir    <= ir_sh;
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// Data registers
	// ****************************************
	logic                 dr_byp;	// One-stage bypass
	logic [31:0]          id_sh;	// Shared id and user signature shifter
	logic [BSR_LEN-1:0]   bsr_sh;	// Boundary shift stage
	logic [BSR_LEN-1:0]   bsr_upd;	// Boundary pattern for the pins

	// Capture and shift of the selected data register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dr_byp  <= 1'b0;
			id_sh   <= '0;
			bsr_sh  <= '0;
			bsr_upd <= '0;
		end else if (rise) begin
			case (state)
				bst_pkg::ST_CAP_DR: begin
					dr_byp <= 1'b0;
					if (sel == bst_pkg::SEL_ID) begin
						id_sh <= {`BST_ID_VERSION, `BST_ID_PART, `BST_ID_MAKER, 1'b1};	// see [R8] [R9]
					end else if (sel == bst_pkg::SEL_USER) begin
						id_sh <= {`BST_USER_FIXED, user_sig};	// see [R2]
					end
					if (sel == bst_pkg::SEL_BSR) begin
						bsr_sh <= pad_s2;	// see [R4] [R5]
					end
				end
				bst_pkg::ST_SH_DR: begin
					dr_byp <= jtag_s2.tdi;	// see [R3]
					if (sel == bst_pkg::SEL_ID || sel == bst_pkg::SEL_USER) begin
						id_sh <= {jtag_s2.tdi, id_sh[31:1]};	// see [R6] [R7]
					end
					if (sel == bst_pkg::SEL_BSR) begin
						bsr_sh <= {jtag_s2.tdi, bsr_sh[BSR_LEN-1:1]};	// see [R10]
					end
				end
				bst_pkg::ST_UPD_DR: begin
					if (sel == bst_pkg::SEL_BSR) begin
						bsr_upd <= bsr_sh;	// see [R4]
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// Configuration stream
	// ****************************************
	// Each shifted bit goes to the loader as a one-cycle strobe
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cfg_bit    <= 1'b0;
			cfg_strobe <= 1'b0;
			cfg_start  <= 1'b0;
		end else begin
			cfg_strobe <= rise && state == bst_pkg::ST_SH_DR && sel == bst_pkg::SEL_CFG;	// see [R12]
			cfg_start  <= rise && state == bst_pkg::ST_UPD_IR && ir_sh == `BST_OP_CFG_START;	// see [R12]
			if (rise && state == bst_pkg::ST_SH_DR && sel == bst_pkg::SEL_CFG) begin
				cfg_bit <= jtag_s2.tdi;
			end
		end
	end

	// ****************************************
	// TDO driver
	// ****************************************
	logic tdo_src;	// Bit presented at the next fall

	always_comb begin
		tdo_src = dr_byp;
		if (state == bst_pkg::ST_SH_IR) begin
			tdo_src = ir_sh[0];
		end else begin
			case (sel)
				bst_pkg::SEL_BSR:  tdo_src = bsr_sh[0];
				bst_pkg::SEL_ID,
				bst_pkg::SEL_USER: tdo_src = id_sh[0];
				bst_pkg::SEL_CFG:  tdo_src = cfg_bit;
				default:           tdo_src = dr_byp;
			endcase
		end
	end

	// Falling edge launch gives the far end half a period of setup
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tdo    <= 1'b1;
			tdo_oe <= 1'b0;
		end else if (fall) begin
			tdo    <= tdo_src;	// see [R16]
			tdo_oe <= state == bst_pkg::ST_SH_IR || state == bst_pkg::ST_SH_DR;	// see [R16]
		end
	end

	// ****************************************
	// Pad drivers
	// ****************************************
	logic [BSR_LEN-1:0] od_q;	// Open-drain selection seen by the pads

	for (genvar i = 0; i < BSR_LEN; i++) begin : g_pad
		logic val;	// Value wanted on the pin
		logic en;	// Pin wants to drive
		assign val = extest_act ? bsr_upd[i] : core_out[i];	// see [R5]
		assign en  = extest_act ? 1'b1 : core_oe[i];

		// Open-drain pins only pull low; power gate holds all off
		always_ff @(posedge core_clk or posedge rst) begin
			if (rst) begin
				pad_out[i] <= 1'b0;
				pad_oe[i]  <= 1'b0;
				od_q[i]    <= 1'b0;
			end else begin
				od_q[i]    <= od_sel[i];
				pad_out[i] <= od_sel[i] ? 1'b0 : val;	// see [R15]
				pad_oe[i]  <= pwr_ok && en && !(od_sel[i] && val);	// see [R14] [R15]
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_ir_reset_sel: assert property ( // see [R17]
		rise && state == bst_pkg::ST_RESET |=> ir == `BST_OP_IDCODE)
		else $error("Reset did not select idcode");
	a_ir_shift_in: assert property ( // see [R1]
		rise && state == bst_pkg::ST_SH_IR |=> ir_sh[9] == $past(jtag_s2.tdi))
		else $error("Instruction bit not shifted in at top");
	a_tdo_on_fall: assert property ( // see [R16]
		$changed(tdo) || $changed(tdo_oe) |-> $past(fall))
		else $error("TDO moved outside a falling edge");
	a_tdo_float: assert property ( // see [R16]
		fall && state != bst_pkg::ST_SH_DR && state != bst_pkg::ST_SH_IR |=> !tdo_oe)
		else $error("TDO driven outside shift");
	a_bypass_stage: assert property ( // see [R3]
		rise && state == bst_pkg::ST_SH_DR && sel == bst_pkg::SEL_BYP
			|=> dr_byp == $past(jtag_s2.tdi))
		else $error("Bypass stage lost the bit");
	a_id_lsb_one: assert property ( // see [R8] [R9]
		rise && state == bst_pkg::ST_CAP_DR && sel == bst_pkg::SEL_ID
			|=> id_sh[0] && id_sh[31:28] == `BST_ID_VERSION)
		else $error("Id capture wrong");
	a_user_capture: assert property ( // see [R2] [R6]
		rise && state == bst_pkg::ST_CAP_DR && sel == bst_pkg::SEL_USER
			|=> id_sh == {`BST_USER_FIXED, $past(user_sig)})
		else $error("User signature capture wrong");
	a_bsr_capture: assert property ( // see [R4]
		rise && state == bst_pkg::ST_CAP_DR && sel == bst_pkg::SEL_BSR
			|=> bsr_sh == $past(pad_s2))
		else $error("Boundary capture wrong");
	a_busy_block: assert property ( // see [R11]
		cfg_busy |-> sel != bst_pkg::SEL_BSR && !extest_act)
		else $error("Scan active during configuration");
	a_power_float: assert property ( // see [R14]
		!pwr_ok |=> pad_oe == '0)
		else $error("Pads driven before power good");
	a_od_no_high: assert property ( // see [R15]
		(pad_oe & pad_out & od_q) == '0)
		else $error("Open-drain pin driven high");
	// Open-drain pads take part: they pull low for a zero, else float
	a_extest_drive: assert property ( // see [R5] [R15]
		extest_act && pwr_ok
			|=> pad_out == ($past(bsr_upd) & ~$past(od_sel))
			&& pad_oe == ~($past(bsr_upd) & $past(od_sel)))
		else $error("Extest pattern not on pads");

	c_ir_update:  cover property (rise && state == bst_pkg::ST_UPD_IR);
	c_id_shift:   cover property (rise && state == bst_pkg::ST_SH_DR && sel == bst_pkg::SEL_ID);
	c_extest:     cover property (extest_act && pwr_ok);
	c_cfg_stream: cover property (cfg_strobe);

endmodule

// ===== tb/bst_jtag_ctl.sv
`timescale 1ns/1ns

// ****************************************
// Far-side test controller model
// ****************************************
module bst_jtag_ctl (
	output bst_pkg::bst_jtag_t jtag,
	input  wire logic          tdo,
	input  wire logic          tdo_oe
);
	logic last_tdo;	// Last level seen while driven
	logic tdo_line;	// Resolved wire level

	// Released wire shows the inverse, so a missing enable is caught
	assign tdo_line = tdo_oe ? tdo : ~last_tdo;

	// Track the driven level
	always @(tdo or tdo_oe) begin
		if (tdo_oe === 1'b1) begin
			last_tdo = tdo;
		end
	end

	// Clock stands high between frames
	initial begin
		last_tdo = 1'b0;
		jtag     = 3'b111;
	end

	// One test clock: pins change on the fall, output sampled before the rise
	task automatic tick(input logic ms, input logic di, output logic do_v);
		jtag.tck = 1'b0;
		jtag.tms = ms;
		jtag.tdi = di;
		#40;
		do_v = tdo_line;
		jtag.tck = 1'b1;
		#40;
	endtask

	// Five high selects reach reset from any state, then park in idle
	task automatic reset_tap();
		logic b;
		repeat (5) tick(1'b1, 1'b1, b);
		tick(1'b0, 1'b1, b);
	endtask

	// Full scan from idle back to idle; exactly n bits, LSB first
	task automatic scan(input logic is_ir, input int n, input logic [1445:0] din,
			output logic [1445:0] dout);
		logic b;
		dout = '0;
		tick(1'b1, 1'b1, b);
		if (is_ir) begin
			tick(1'b1, 1'b1, b);
		end
		tick(1'b0, 1'b1, b);
		tick(1'b0, 1'b1, b);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], b);
			dout[i] = b;
		end
		tick(1'b1, 1'b1, b);
		tick(1'b0, 1'b1, b);
	endtask
endmodule

// ===== tb/boundary_scan_tap_tb.sv
`timescale 1ns/1ns
`include "bst_consts.svh"

// ****************************************
// Self-checking bench for the test port
// ****************************************
module boundary_scan_tap_tb;
	localparam int          L      = `BST_BSR_LEN_DEF;	// Shortest variant
	localparam logic [31:0] ID_EXP = {`BST_ID_VERSION, `BST_ID_PART, `BST_ID_MAKER, 1'b1};
	localparam logic [31:0] BP     = 32'h6e21d04b;	// Bypass pattern

	typedef struct packed {
		logic [9:0]  op;
		logic [31:0] din;
		logic [31:0] exp;
	} bst_row_t;

	logic               core_clk, rst, tdo, tdo_oe, cfg_busy, power_good;
	logic               cfg_start, cfg_bit, cfg_strobe;
	logic [6:0]         user_sig;
	logic [L-1:0]       core_out, core_oe, od_sel, pad_in, pad_out, pad_oe;
	logic [L-1:0]       pre, ext_out, ext_oe;	// Preload and its pad image
	logic [1445:0]      got;	// Scan result
	logic [15:0]        cfg_q;	// Collected configuration bits
	bst_pkg::bst_jtag_t jtag;
	bst_row_t           rows [5];
	int                 err_total, num_checks, n_start, n_strobe, cyc;

	// Clock
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	bst_tap u_dut (.core_clk(core_clk), .rst(rst), .jtag_in(jtag), .tdo(tdo),
		.tdo_oe(tdo_oe), .user_sig(user_sig), .cfg_busy(cfg_busy),
		.power_good(power_good), .core_out(core_out), .core_oe(core_oe),
		.od_sel(od_sel), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.cfg_start(cfg_start), .cfg_bit(cfg_bit), .cfg_strobe(cfg_strobe));

	bst_jtag_ctl u_ctl (.jtag(jtag), .tdo(tdo), .tdo_oe(tdo_oe));

	task automatic chk(input string what, input logic [1445:0] exp,
			input logic [1445:0] got_v);
		num_checks++;
		if (got_v !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got_v);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Core inputs change shortly after a rising edge
	task automatic edges(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// Pulse counters and hang guard; the ceiling leaves room over about 37k cycles
	always @(posedge core_clk) begin
		cyc++;
		if (cfg_start === 1'b1) begin
			n_start++;
		end
		if (cfg_strobe === 1'b1) begin
			cfg_q = {cfg_bit, cfg_q[15:1]};
			n_strobe++;
		end
		if (cyc == 60000) begin
			err_total++;
			$display("MISMATCH timeout expected done seen running");
			summarize();
		end
	end

	// Main sequence
	initial begin
		rst = 1'b1;
		cfg_busy = 1'b0;
		power_good = 1'b0;
		user_sig = 7'h5b;
		od_sel = '0;
		od_sel[1:0] = 2'b11;	// Two open-drain pads
		for (int i = 0; i < L; i++) begin
			core_out[i] = i[1];
			core_oe[i] = ~i[2];
			pad_in[i] = i[0] ^ i[3];
			pre[i] = (i % 3 == 0);
			ext_out[i] = od_sel[i] ? 1'b0 : pre[i];
			ext_oe[i] = od_sel[i] ? ~pre[i] : 1'b1;
		end
		rows[0] = '{`BST_OP_IDCODE, 32'h12345678, ID_EXP};
		rows[1] = '{`BST_OP_USERCODE, 32'h0, {`BST_USER_FIXED, 7'h5b}};
		rows[2] = '{`BST_OP_BYPASS, BP, {BP[30:0], 1'b0}};
		rows[3] = '{10'h3aa, BP, {BP[30:0], 1'b0}};
		rows[4] = '{`BST_OP_CFG_START, BP, {BP[30:0], 1'b0}};
		edges(3);
		rst = 1'b0;
		edges(4);
		chk("pad_oe_unpowered", '0, pad_oe);
		chk("tdo_oe_idle", 1'b0, tdo_oe);
		power_good = 1'b1;
		edges(6);
		chk("pad_out_user", core_out, pad_out);
		chk("pad_oe_user", core_oe, pad_oe);
		// Port wakes in test reset; walk to idle before any scan
		u_ctl.reset_tap();
		u_ctl.scan(1'b0, 32, '0, got);
		chk("id_after_reset", ID_EXP, got[31:0]);
		// ****************************************
		// Table of instruction rows
		// ****************************************
		foreach (rows[k]) begin
			u_ctl.scan(1'b1, 10, rows[k].op, got);
			chk("ir_capture", `BST_IR_CAPTURE, got[9:0]);
			u_ctl.scan(1'b0, 32, rows[k].din, got);
			chk("dr_out", rows[k].exp, got[31:0]);
		end
		chk("cfg_start_pulses", 1, n_start);
		// ****************************************
		// Boundary cases
		// ****************************************
		u_ctl.scan(1'b1, 10, `BST_OP_SAMPLE, got);
		u_ctl.scan(1'b0, L, pre, got);
		chk("sample_capture", pad_in, got[L-1:0]);
		chk("sample_pads", core_out, pad_out);
		u_ctl.scan(1'b1, 10, `BST_OP_EXTEST, got);
		edges(4);
		chk("extest_out", ext_out, pad_out);
		chk("extest_oe", ext_oe, pad_oe);
		u_ctl.scan(1'b0, L, pre, got);
		chk("extest_capture", pad_in, got[L-1:0]);
		// Configuring blocks the boundary path
		cfg_busy = 1'b1;
		edges(4);
		chk("busy_pads", core_out, pad_out);
		u_ctl.scan(1'b0, 32, BP, got);
		chk("busy_bypass", {BP[30:0], 1'b0}, got[31:0]);
		cfg_busy = 1'b0;
		u_ctl.reset_tap();
		edges(4);
		chk("tdo_oe_reset", 1'b0, tdo_oe);
		chk("reset_pads", core_out, pad_out);
		u_ctl.scan(1'b0, 32, '0, got);
		chk("reset_id", ID_EXP, got[31:0]);
		u_ctl.scan(1'b1, 10, `BST_OP_CFG_LOAD, got);
		u_ctl.scan(1'b0, 16, 16'hb38d, got);
		edges(4);
		chk("cfg_strobes", 16, n_strobe);
		chk("cfg_bits", 16'hb38d, cfg_q);
		summarize();
	end
endmodule
